// >>> src/mpq_queue.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
module mpq_queue (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire mpq_pkg::mpq_apb_req_t i_apb,
    input wire logic i_motion_done,
    input wire logic i_error_stop,
    input wire logic i_cmp_true,
    output mpq_pkg::mpq_apb_rsp_t o_apb,
    output mpq_pkg::mpq_op_set_t o_working,
    output logic [31:0] o_cmp5_value,
    output logic o_running,
    output logic o_motion_start,
    output logic o_motion_stop,
    output logic o_override,
    output logic o_int
);

    typedef struct packed {
        mpq_pkg::mpq_apb_rsp_t apb;
        mpq_pkg::mpq_op_set_t pend;
        mpq_pkg::mpq_op_set_t lay1;
        mpq_pkg::mpq_op_set_t lay2;
        mpq_pkg::mpq_op_set_t work;
        logic [1:0] op_lvl;
        logic [31:0] cmp_work;
        logic [31:0] cmp_lay1;
        logic [31:0] cmp_lay2;
        logic [1:0] cmp_lvl;
        logic cmp_prev;
        logic [1:0] irq_en;
        logic start;
        logic stop;
        logic override;
        logic run;
        logic irq;
    } mpq_state_t;

    mpq_state_t s_q;
    mpq_state_t s_d;

    logic wr_acc;
    logic [11:0] addr;
    logic [31:0] wd;
    logic stopped;
    logic cmd_start;
    logic cmd_stop;
    logic cmp_rise;
    logic [31:0] rdata;
    logic hit;

    assign addr = i_apb.paddr;
    assign wd = i_apb.pwdata;
    // a write lands only on the access edge that sees pready
    assign wr_acc = i_apb.psel & i_apb.penable & i_apb.pwrite & s_q.apb.pready;
    assign stopped = (s_q.op_lvl == mpq_pkg::LVL_NONE);
    assign cmd_start = wr_acc && addr == mpq_pkg::OFS_COMMAND
        && wd[7:0] == mpq_pkg::CMD_START;
    assign cmd_stop = wr_acc && addr == mpq_pkg::OFS_COMMAND
        && (wd[7:0] == mpq_pkg::CMD_STOP_DEC
        || wd[7:0] == mpq_pkg::CMD_STOP_IMM);
    assign cmp_rise = i_cmp_true & ~s_q.cmp_prev;

    always_comb begin
        hit = 1'b1;
        rdata = mpq_pkg::RST_WORD;
        case (addr)
            mpq_pkg::OFS_POS_QUEUE: rdata = s_q.pend.pos;
            mpq_pkg::OFS_POS_WORKING: rdata = s_q.work.pos;
            mpq_pkg::OFS_FL_QUEUE: rdata = {16'h0000, s_q.pend.fl};
            mpq_pkg::OFS_FL_WORKING: rdata = {16'h0000, s_q.work.fl};
            mpq_pkg::OFS_FH_QUEUE: rdata = {16'h0000, s_q.pend.fh};
            mpq_pkg::OFS_FH_WORKING: rdata = {16'h0000, s_q.work.fh};
            mpq_pkg::OFS_CMP5_QUEUE: rdata = s_q.cmp_lay1;
            mpq_pkg::OFS_CMP5_WORKING: rdata = s_q.cmp_work;
            mpq_pkg::OFS_COMMAND: rdata = mpq_pkg::RST_WORD;
            mpq_pkg::OFS_MAIN_STATUS: begin
                rdata[mpq_pkg::MSW_OP_FULL] =
                    (s_q.op_lvl == mpq_pkg::LVL_FULL);
                rdata[mpq_pkg::MSW_CMP_FULL] =
                    (s_q.cmp_lvl == mpq_pkg::LVL_FULL);
                rdata[mpq_pkg::MSW_RUNNING] = ~stopped;
            end
            mpq_pkg::OFS_EXT_STATUS: begin
                rdata[mpq_pkg::EXT_OP_LVL +: 2] = s_q.op_lvl;
                rdata[mpq_pkg::EXT_CMP_LVL +: 2] = s_q.cmp_lvl;
            end
            mpq_pkg::OFS_IRQ_ENABLE: rdata = {30'h0000_0000, s_q.irq_en};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.stop = 1'b0;
        s_d.override = 1'b0;
        s_d.irq = 1'b0;
        s_d.cmp_prev = i_cmp_true;

        // bus slave: no wait states, answer registered at setup edge
        s_d.apb.pready = i_apb.psel & ~i_apb.penable;
        if (i_apb.psel && !i_apb.penable) begin
            s_d.apb.prdata = i_apb.pwrite ? mpq_pkg::RST_WORD : rdata;
            s_d.apb.pslverr = ~hit;
        end else begin
            s_d.apb.prdata = mpq_pkg::RST_WORD;
            s_d.apb.pslverr = 1'b0;
        end

        if (wr_acc) begin
            case (addr)
                mpq_pkg::OFS_POS_QUEUE: begin
                    s_d.pend.pos = wd;
                    if (stopped) begin
                        s_d.work.pos = wd;
                    end
                end
                mpq_pkg::OFS_FL_QUEUE: begin
                    s_d.pend.fl = wd[15:0];
                    if (stopped) begin
                        s_d.work.fl = wd[15:0];
                    end
                end
                mpq_pkg::OFS_FH_QUEUE: begin
                    s_d.pend.fh = wd[15:0];
                    if (stopped) begin
                        s_d.work.fh = wd[15:0];
                    end
                end
                mpq_pkg::OFS_POS_WORKING: begin
                    s_d.work.pos = wd;
                    s_d.override = ~stopped;
                end
                mpq_pkg::OFS_FL_WORKING: begin
                    s_d.work.fl = wd[15:0];
                    s_d.override = ~stopped;
                end
                mpq_pkg::OFS_FH_WORKING: begin
                    s_d.work.fh = wd[15:0];
                    s_d.override = ~stopped;
                end
                mpq_pkg::OFS_CMP5_WORKING: begin
                    s_d.cmp_work = wd;
                end
                mpq_pkg::OFS_IRQ_ENABLE: begin
                    s_d.irq_en = wd[1:0];
                end
                default: begin
                end
            endcase
        end

        // operation queue; start and completion never coincide usefully,
        // so completion takes priority and a start in the same cycle is dropped
        if (i_motion_done && !stopped) begin
            case (s_q.op_lvl)
                mpq_pkg::LVL_FULL: begin
                    s_d.work = s_q.lay1;
                    s_d.lay1 = s_q.lay2;
                    s_d.op_lvl = mpq_pkg::LVL_ONE;
                    s_d.start = 1'b1;
                    s_d.irq = s_q.irq_en[mpq_pkg::IRQ_OP_ADV];
                end
                mpq_pkg::LVL_ONE: begin
                    s_d.work = s_q.lay1;
                    s_d.op_lvl = mpq_pkg::LVL_WORK;
                    s_d.start = 1'b1;
                end
                default: s_d.op_lvl = mpq_pkg::LVL_NONE;
            endcase
        end else if (cmd_start) begin
            case (s_q.op_lvl)
                mpq_pkg::LVL_NONE: begin
                    s_d.op_lvl = mpq_pkg::LVL_WORK;
                    s_d.start = 1'b1;
                end
                mpq_pkg::LVL_WORK: begin
                    s_d.lay1 = s_q.pend;
                    s_d.op_lvl = mpq_pkg::LVL_ONE;
                end
                mpq_pkg::LVL_ONE: begin
                    s_d.lay2 = s_q.pend;
                    s_d.op_lvl = mpq_pkg::LVL_FULL;
                end
                default: begin
                    // full: start dropped, nothing moves
                end
            endcase
        end

        if (cmd_stop || i_error_stop) begin
            s_d.op_lvl = mpq_pkg::LVL_NONE;
            s_d.start = 1'b0;
            s_d.stop = 1'b1;
        end else if (wr_acc && addr == mpq_pkg::OFS_COMMAND
            && wd[7:0] == mpq_pkg::CMD_OP_CANCEL
            && s_q.op_lvl != mpq_pkg::LVL_NONE) begin
            s_d.op_lvl = mpq_pkg::LVL_WORK;
        end

        // compare queue, independent of motion
        if (cmp_rise) begin
            case (s_q.cmp_lvl)
                mpq_pkg::LVL_FULL: begin
                    s_d.cmp_work = s_q.cmp_lay1;
                    s_d.cmp_lay1 = s_q.cmp_lay2;
                    s_d.cmp_lvl = mpq_pkg::LVL_ONE;
                    s_d.irq = s_d.irq
                        | s_q.irq_en[mpq_pkg::IRQ_CMP_ADV];
                end
                mpq_pkg::LVL_ONE: begin
                    s_d.cmp_work = s_q.cmp_lay1;
                    s_d.cmp_lvl = mpq_pkg::LVL_WORK;
                end
                default: begin
                end
            endcase
        end else if (wr_acc && addr == mpq_pkg::OFS_CMP5_QUEUE) begin
            case (s_q.cmp_lvl)
                mpq_pkg::LVL_NONE: begin
                    s_d.cmp_work = wd;
                    s_d.cmp_lvl = mpq_pkg::LVL_WORK;
                end
                mpq_pkg::LVL_WORK: begin
                    s_d.cmp_lay1 = wd;
                    s_d.cmp_lvl = mpq_pkg::LVL_ONE;
                end
                mpq_pkg::LVL_ONE: begin
                    s_d.cmp_lay2 = wd;
                    s_d.cmp_lvl = mpq_pkg::LVL_FULL;
                end
                default: begin
                    // full: write dropped
                end
            endcase
        end else if (wr_acc && addr == mpq_pkg::OFS_COMMAND
            && wd[7:0] == mpq_pkg::CMD_CMP_CANCEL
            && s_q.cmp_lvl != mpq_pkg::LVL_NONE) begin
            s_d.cmp_lvl = mpq_pkg::LVL_WORK;
        end

        // running flag kept as a flop so the output needs no decode
        s_d.run = (s_d.op_lvl != mpq_pkg::LVL_NONE);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // all outputs come straight from state flops
    assign o_apb = s_q.apb;
    assign o_working = s_q.work;
    assign o_cmp5_value = s_q.cmp_work;
    assign o_running = s_q.run;
    assign o_motion_start = s_q.start;
    assign o_motion_stop = s_q.stop;
    assign o_override = s_q.override;
    assign o_int = s_q.irq;

endmodule : mpq_queue

// >>> src/mpq_pkg.sv
package mpq_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_POS_QUEUE = 12'h000;
    localparam logic [11:0] OFS_POS_WORKING = 12'h004;
    localparam logic [11:0] OFS_FL_QUEUE = 12'h008;
    localparam logic [11:0] OFS_FL_WORKING = 12'h00C;
    localparam logic [11:0] OFS_FH_QUEUE = 12'h010;
    localparam logic [11:0] OFS_FH_WORKING = 12'h014;
    localparam logic [11:0] OFS_CMP5_QUEUE = 12'h018;
    localparam logic [11:0] OFS_CMP5_WORKING = 12'h01C;
    localparam logic [11:0] OFS_COMMAND = 12'h020;
    localparam logic [11:0] OFS_MAIN_STATUS = 12'h024;
    localparam logic [11:0] OFS_EXT_STATUS = 12'h028;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h02C;

    // command codes
    localparam logic [7:0] CMD_START = 8'h50;
    localparam logic [7:0] CMD_OP_CANCEL = 8'h26;
    localparam logic [7:0] CMD_CMP_CANCEL = 8'h27;
    localparam logic [7:0] CMD_STOP_DEC = 8'h49;
    localparam logic [7:0] CMD_STOP_IMM = 8'h4A;

    // queue fill levels
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_WORK = 2'h1;
    localparam logic [1:0] LVL_ONE = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;

    // field positions
    localparam int MSW_OP_FULL = 0;
    localparam int MSW_CMP_FULL = 1;
    localparam int MSW_RUNNING = 2;
    localparam int EXT_OP_LVL = 0;
    localparam int EXT_CMP_LVL = 2;
    localparam int IRQ_OP_ADV = 0;
    localparam int IRQ_CMP_ADV = 1;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mpq_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mpq_apb_rsp_t;

    typedef struct packed {
        logic [31:0] pos;
        logic [15:0] fl;
        logic [15:0] fh;
    } mpq_op_set_t;
endpackage : mpq_pkg

// >>> sim/mpq_queue_sva.sv
`timescale 1ns/10ps
module mpq_queue_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire mpq_pkg::mpq_apb_req_t i_apb,
    input wire logic i_motion_done,
    input wire logic i_error_stop,
    input wire logic i_cmp_true,
    input wire mpq_pkg::mpq_apb_rsp_t o_apb,
    input wire mpq_pkg::mpq_op_set_t o_working,
    input wire logic [31:0] o_cmp5_value,
    input wire logic o_running,
    input wire logic o_motion_start,
    input wire logic o_motion_stop,
    input wire logic o_override,
    input wire logic o_int
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence wr_s(logic [11:0] a);
        i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite &&
            i_apb.paddr == a;
    endsequence
    sequence cmd_s(logic [7:0] c);
        wr_s(mpq_pkg::OFS_COMMAND) ##0 i_apb.pwdata[7:0] == c;
    endsequence
    sequence stop_s;
        o_motion_stop ##1 !o_running;
    endsequence
    pready_one_a: assert property (i_apb.psel && !i_apb.penable |=>
        o_apb.pready ##1 !o_apb.pready) else $error("pready not one cycle");
    err_ready_a: assert property (o_apb.pslverr |-> o_apb.pready &&
        o_apb.prdata == 32'h0000_0000) else $error("bad error response");
    start_run_a: assert property (
        cmd_s(mpq_pkg::CMD_START) ##0 !o_running |=> o_motion_start &&
        o_running) else $error("start command did not start motion");
    stop_cmd_a: assert property (
        (cmd_s(mpq_pkg::CMD_STOP_DEC) or cmd_s(mpq_pkg::CMD_STOP_IMM))
        ##0 o_running |=> stop_s) else $error("stop command not obeyed");
    error_stop_a: assert property (i_error_stop && o_running |=>
        stop_s) else $error("error stop not obeyed");
    work_override_a: assert property (
        (wr_s(mpq_pkg::OFS_FH_WORKING) or wr_s(mpq_pkg::OFS_POS_WORKING))
        ##0 o_running |=> o_override) else $error("override missing");
    int_cause_a: assert property (
        o_int |-> $past(i_motion_done) ||
        ($past(i_cmp_true) && !$past(i_cmp_true, 2)))
        else $error("interrupt without advance");
    cmp_direct_a: assert property (
        wr_s(mpq_pkg::OFS_CMP5_WORKING) |=>
        o_cmp5_value == $past(i_apb.pwdata)) else $error("cmp5 not replaced");
    done_idle_a: assert property (i_motion_done && !o_running |=>
        !o_motion_start && !o_int) else $error("done acted while stopped");
endmodule : mpq_queue_sva
bind mpq_queue mpq_queue_sva u_sva (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_apb(i_apb), .i_motion_done(i_motion_done),
    .i_error_stop(i_error_stop), .i_cmp_true(i_cmp_true), .o_apb(o_apb),
    .o_working(o_working), .o_cmp5_value(o_cmp5_value),
    .o_running(o_running), .o_motion_start(o_motion_start),
    .o_motion_stop(o_motion_stop), .o_override(o_override), .o_int(o_int));

// >>> sim/mpq_motion_model.sv
`timescale 1ns/10ps
module mpq_motion_model #(
    parameter int RUN_CYCLES = 100
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_stop,
    output logic o_done
);
    int cnt_q;
    // one completion per motion cycle, never per pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt_q == 1);
            if (i_start) begin
                cnt_q <= RUN_CYCLES;
            end else if (i_stop) begin
                cnt_q <= 0;
            end else if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : mpq_motion_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic i_clk_sys;
    logic i_rst_n;
    mpq_pkg::mpq_apb_req_t req;
    mpq_pkg::mpq_apb_rsp_t rsp;
    mpq_pkg::mpq_op_set_t work;
    logic [31:0] cmp5;
    logic [31:0] rdat;
    logic rerr;
    logic done, err_stop, cmp_true, running, start, stop, irq;
    int mismatches;
    int samples_checked;
    mpq_queue uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_apb(req),
        .i_motion_done(done), .i_error_stop(err_stop), .i_cmp_true(cmp_true),
        .o_apb(rsp), .o_working(work), .o_cmp5_value(cmp5),
        .o_running(running), .o_motion_start(start), .o_motion_stop(stop),
        .o_override(), .o_int(irq));
    mpq_motion_model u_motion (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_start(start), .i_stop(stop), .o_done(done));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge i_clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        check(32'(rsp.pready), 32'h0000_0001);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        check(rdat, e);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic cmd(input logic [7:0] c);
        wr(mpq_pkg::OFS_COMMAND, {24'h00_0000, c});
    endtask : cmd
    task automatic wait_int;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge i_clk_sys);
            n++;
        end
        check(32'(irq), 32'h0000_0001);
    endtask : wait_int
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        mismatches++;
        wrap_up();
    end
    initial begin
        req = '0;
        {err_stop, cmp_true, i_rst_n} = 3'h0;
        mismatches = 0;
        samples_checked = 0;
        repeat (20) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        for (int a = 0; a < 48; a += 4) rd(12'(a), 32'h0000_0000);
        xfer(1'b0, 12'h030, 32'h0000_0000);
        // error flag stands only in the access cycle, so xfer latches it
        check(32'(rerr), 32'h0000_0001);
        wr(mpq_pkg::OFS_FH_QUEUE, 32'hABCD_1234);
        rd(mpq_pkg::OFS_FH_WORKING, 32'h0000_1234);
        wr(mpq_pkg::OFS_POS_QUEUE, 32'hFFFF_FFFB);
        check(work.pos, 32'hFFFF_FFFB);
        wr(mpq_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
        cmd(mpq_pkg::CMD_START);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0001);
        wr(mpq_pkg::OFS_POS_QUEUE, 32'h0000_0002);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0001);
        cmd(mpq_pkg::CMD_START);
        wr(mpq_pkg::OFS_FH_WORKING, 32'h0000_0077);
        rd(mpq_pkg::OFS_FH_WORKING, 32'h0000_0077);
        wr(mpq_pkg::OFS_POS_QUEUE, 32'h0000_0003);
        cmd(mpq_pkg::CMD_START);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0003);
        rd(mpq_pkg::OFS_MAIN_STATUS, 32'h0000_0005);
        // host oversteps the full queue on purpose
        wr(mpq_pkg::OFS_POS_QUEUE, 32'h0000_0004);
        cmd(mpq_pkg::CMD_START);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0003);
        wait_int();
        check(work.pos, 32'h0000_0002);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0002);
        cmd(mpq_pkg::CMD_OP_CANCEL);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0001);
        cmd(mpq_pkg::CMD_STOP_IMM);
        rd(mpq_pkg::OFS_MAIN_STATUS, 32'h0000_0000);
        cmd(mpq_pkg::CMD_START);
        cmd(mpq_pkg::CMD_STOP_DEC);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0000);
        cmd(mpq_pkg::CMD_START);
        cmd(mpq_pkg::CMD_START);
        err_stop <= 1'b1;
        @(posedge i_clk_sys);
        err_stop <= 1'b0;
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0000);
        wr(mpq_pkg::OFS_CMP5_QUEUE, 32'h0000_0001);
        check(cmp5, 32'h0000_0001);
        wr(mpq_pkg::OFS_CMP5_QUEUE, 32'h0000_0002);
        wr(mpq_pkg::OFS_CMP5_QUEUE, 32'h0000_0003);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_000C);
        rd(mpq_pkg::OFS_MAIN_STATUS, 32'h0000_0002);
        wr(mpq_pkg::OFS_CMP5_QUEUE, 32'h0000_0004);
        rd(mpq_pkg::OFS_CMP5_QUEUE, 32'h0000_0002);
        cmp_true <= 1'b1;
        wait_int();
        check(cmp5, 32'h0000_0002);
        cmp_true <= 1'b0;
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0008);
        wr(mpq_pkg::OFS_CMP5_WORKING, 32'h0000_0009);
        check(cmp5, 32'h0000_0009);
        cmd(mpq_pkg::CMD_CMP_CANCEL);
        rd(mpq_pkg::OFS_EXT_STATUS, 32'h0000_0004);
        check(cmp5, 32'h0000_0009);
        wrap_up();
    end
endmodule : tb_top
